// ---- rrn_regs.vh ----
// Purpose: Register map, field positions, reset values and timing figures of the ring node control.
// Assumes: Byte addresses on a 32-bit register port.
// Notes:   Definitions only.
`ifndef RRN_REGS_VH
`define RRN_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RRN_ADDR_CONTROL     32'h44053C00
`define RRN_ADDR_STATUS      32'h44053C04
`define RRN_ADDR_FRAME_TYPE  32'h44053C08
`define RRN_ADDR_IRQ_MASK    32'h44053C0C
`define RRN_ADDR_IRQ_STATUS  32'h44053C10
`define RRN_ADDR_TIMEOUT_CAP 32'h44053C14
`define RRN_ADDR_STATS       32'h44053C18

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define RRN_CTL_ENABLE       0
`define RRN_CTL_AUTO_PURGE   1
`define RRN_CTL_DROP_BAD_TMO 4
`define RRN_CTL_TICK_LSB     8
`define RRN_CTL_TICK_MSB     19
`define RRN_ST_TOPO_LSB      24
`define RRN_ST_LINK_LSB      16
`define RRN_ST_NODE_LSB      8

`define RRN_TOPO_LINEAR      8'h00
`define RRN_TOPO_RING        8'h01
`define RRN_NODE_IDLE        8'h00
`define RRN_NODE_NORMAL      8'h01
`define RRN_NODE_FAULT       8'h02

// Interrupt status and mask bit positions.
`define RRN_IRQ_STATE_CHG    0
`define RRN_IRQ_FLUSH        1
`define RRN_IRQ_BAD_TMO      2
`define RRN_IRQ_DISCARD0     3
`define RRN_IRQ_BEACON0      5
`define RRN_IRQ_EXPIRE0      7
`define RRN_IRQ_BITS         9

// ----------------------------------------------------------------------------
// Reset values and purge port mask
// ----------------------------------------------------------------------------
`define RRN_TICK_RESET       12'h064
`define RRN_ETYPE_RESET      16'h0000
`define RRN_PURGE_MASK       8'h03

// ----------------------------------------------------------------------------
// Timing, in microseconds
// ----------------------------------------------------------------------------
`define RRN_TMO_MIN_US       32'h000000C8
`define RRN_TMO_MAX_US       32'h0007A120

`endif

// ---- rrn_ctrl.v ----
// Purpose: Ring redundancy node control and status for two ring ports of a switch.
// Assumes: One clock; frame descriptors arrive as one-cycle pulses after the header is parsed.
// Notes:   Registers reached over a plain strobe port with read data one cycle later.
`include "rrn_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module rrn_ctrl #(
	parameter TMO_W = 32
) (
	input  wire              clk,
	input  wire              resetn,
	input  wire [31:0]       reg_addr,
	input  wire [31:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [31:0]       reg_rdata,
	input  wire              rx_valid,
	input  wire              rx_port,
	input  wire [15:0]       rx_ethertype,
	input  wire [47:0]       rx_src_addr,
	input  wire              rx_beacon,
	input  wire              rx_from_sup,
	input  wire              rx_ring_fault,
	input  wire [TMO_W-1:0]  rx_timeout,
	input  wire [47:0]       local_addr,
	input  wire [1:0]        link_up,
	output reg               rx_done,
	output reg               rx_drop,
	output reg               rx_ring_frame,
	output reg               purge_req,
	output reg  [7:0]        purge_port_mask,
	input  wire              purge_ack,
	output wire              irq
);

	// ------------------------------------------------------------------------
	// Node states
	// ------------------------------------------------------------------------
	localparam [2:0] ST_IDLE   = 3'b001;
	localparam [2:0] ST_NORMAL = 3'b010;
	localparam [2:0] ST_FAULT  = 3'b100;

	function [7:0] node_code;
		input [2:0] st;
		begin
			case (st)
				ST_NORMAL: node_code = `RRN_NODE_NORMAL;
				ST_FAULT:  node_code = `RRN_NODE_FAULT;
				default:   node_code = `RRN_NODE_IDLE;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------------
	reg                   enable;
	reg                   auto_table_purge;
	reg                   drop_bad_timeout_beacons;
	reg  [11:0]           microsecond_tick_count;
	reg  [15:0]           ring_frame_ethertype;
	reg  [`RRN_IRQ_BITS-1:0] irq_mask;
	reg  [`RRN_IRQ_BITS-1:0] irq_status;
	reg  [TMO_W-1:0]      captured_beacon_timeout;
	reg  [15:0]           ring_frame_count;
	reg  [15:0]           ignored_beacon_count;
	reg  [1:0]            last_beacon_port;
	reg  [2:0]            state;
	reg  [2:0]            next_state;

	wire wr_ctl = reg_wr && (reg_addr == `RRN_ADDR_CONTROL);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			enable                   <= 1'b0;
			auto_table_purge         <= 1'b0;
			drop_bad_timeout_beacons <= 1'b0;
			microsecond_tick_count   <= `RRN_TICK_RESET;
			ring_frame_ethertype     <= `RRN_ETYPE_RESET;
			irq_mask                 <= {`RRN_IRQ_BITS{1'b0}};
		end else if (reg_wr) begin
			if (wr_ctl) begin
				enable                   <= reg_wdata[`RRN_CTL_ENABLE];
				auto_table_purge         <= reg_wdata[`RRN_CTL_AUTO_PURGE];
				drop_bad_timeout_beacons <= reg_wdata[`RRN_CTL_DROP_BAD_TMO];
				microsecond_tick_count   <= reg_wdata[`RRN_CTL_TICK_MSB:`RRN_CTL_TICK_LSB];
			end
			if (reg_addr == `RRN_ADDR_FRAME_TYPE)
				ring_frame_ethertype <= reg_wdata[15:0];
			if (reg_addr == `RRN_ADDR_IRQ_MASK)
				irq_mask <= reg_wdata[`RRN_IRQ_BITS-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Microsecond tick
	// ------------------------------------------------------------------------
	// A zero count is treated as one so the tick never stalls.
	reg  [11:0] tick_cnt;
	wire [11:0] tick_last = (microsecond_tick_count == 12'h000) ? 12'h000 :
		microsecond_tick_count - 12'h001;
	wire        us_tick = (tick_cnt >= tick_last);

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			tick_cnt <= 12'h000;
		else if (us_tick)
			tick_cnt <= 12'h000;
		else
			tick_cnt <= tick_cnt + 12'h001;
	end

	// ------------------------------------------------------------------------
	// Frame classification
	// ------------------------------------------------------------------------
	wire is_ring   = rx_valid && enable && (rx_ethertype == ring_frame_ethertype);
	wire is_beacon = is_ring && rx_beacon;
	wire tmo_bad   = (rx_timeout < `RRN_TMO_MIN_US) || (rx_timeout > `RRN_TMO_MAX_US);
	wire ignored   = is_beacon && drop_bad_timeout_beacons && tmo_bad;
	wire good_sup  = is_beacon && rx_from_sup && !ignored;
	wire loop_hit  = rx_valid && enable && (rx_src_addr == local_addr);

	// Forwarding verdict; an ignored beacon is not a reason to drop.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_done       <= 1'b0;
			rx_drop       <= 1'b0;
			rx_ring_frame <= 1'b0;
		end else begin
			rx_done       <= rx_valid;
			rx_drop       <= loop_hit;
			rx_ring_frame <= is_ring;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			captured_beacon_timeout <= {TMO_W{1'b0}};
		else if (is_beacon)
			captured_beacon_timeout <= rx_timeout;
	end

	// ------------------------------------------------------------------------
	// Per-port beacon timers
	// ------------------------------------------------------------------------
	wire [1:0] expire;
	wire [1:0] running;
	wire [1:0] beacon_hit;
	wire [1:0] discard_hit;

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			reg [TMO_W-1:0] remain;
			reg             run;
			wire            here = (rx_port == p);
			assign beacon_hit[p]  = good_sup && here;
			assign discard_hit[p] = loop_hit && here;
			assign expire[p]      = run && us_tick && (remain <= {{(TMO_W-1){1'b0}}, 1'b1});
			assign running[p]     = run;
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					remain <= {TMO_W{1'b0}};
					run    <= 1'b0;
				end else if (!enable) begin
					run    <= 1'b0;
				end else if (beacon_hit[p]) begin
					remain <= rx_timeout;
					run    <= 1'b1;
				end else if (expire[p]) begin
					run    <= 1'b0;
				end else if (run && us_tick) begin
					remain <= remain - {{(TMO_W-1){1'b0}}, 1'b1};
				end
			end
			always @(posedge clk or negedge resetn) begin
				if (!resetn)
					last_beacon_port[p] <= 1'b0;
				else if (!enable || expire[p])
					last_beacon_port[p] <= 1'b0;
				else if (beacon_hit[p])
					last_beacon_port[p] <= 1'b1;
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Node state machine
	// ------------------------------------------------------------------------
	wire any_left = |(running & ~expire);

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (good_sup)
					next_state = rx_ring_fault ? ST_FAULT : ST_NORMAL;
			end
			ST_NORMAL: begin
				if (good_sup && rx_ring_fault)
					next_state = ST_FAULT;
				else if (|expire)
					next_state = any_left ? ST_FAULT : ST_IDLE;
			end
			ST_FAULT: begin
				if (good_sup && !rx_ring_fault)
					next_state = ST_NORMAL;
				else if ((|expire) && !any_left)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		if (!enable)
			next_state = ST_IDLE;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	wire state_chg = (next_state != state);
	// Entering normal or fault means the ring paths changed, so learned entries are stale.
	wire flush_evt = state_chg && (next_state != ST_IDLE);

	// ------------------------------------------------------------------------
	// Table purge request
	// ------------------------------------------------------------------------
	wire purge_start = flush_evt && auto_table_purge;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			purge_req       <= 1'b0;
			purge_port_mask <= 8'h00;
		end else if (purge_start) begin
			purge_req       <= 1'b1;
			purge_port_mask <= `RRN_PURGE_MASK;
		end else if (purge_ack) begin
			purge_req       <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Statistics
	// ------------------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ring_frame_count     <= 16'h0000;
			ignored_beacon_count <= 16'h0000;
		end else if (!enable) begin
			ring_frame_count     <= 16'h0000;
			ignored_beacon_count <= 16'h0000;
		end else begin
			if (is_ring)
				ring_frame_count <= ring_frame_count + 16'h0001;
			if (ignored)
				ignored_beacon_count <= ignored_beacon_count + 16'h0001;
		end
	end

	// ------------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------------
	reg [`RRN_IRQ_BITS-1:0] irq_set;

	always @* begin
		irq_set = {`RRN_IRQ_BITS{1'b0}};
		irq_set[`RRN_IRQ_STATE_CHG] = state_chg;
		irq_set[`RRN_IRQ_FLUSH]     = flush_evt;
		irq_set[`RRN_IRQ_BAD_TMO]   = is_beacon && tmo_bad;
		irq_set[`RRN_IRQ_DISCARD0 +: 2] = discard_hit;
		irq_set[`RRN_IRQ_BEACON0 +: 2]  = beacon_hit;
		irq_set[`RRN_IRQ_EXPIRE0 +: 2]  = expire;
	end

	// A set in the same cycle as a write-one-to-clear survives the clear.
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			irq_status <= {`RRN_IRQ_BITS{1'b0}};
		else if (reg_wr && (reg_addr == `RRN_ADDR_IRQ_STATUS))
			irq_status <= (irq_status & ~reg_wdata[`RRN_IRQ_BITS-1:0]) | irq_set;
		else
			irq_status <= irq_status | irq_set;
	end

	assign irq = |(irq_status & irq_mask);

	// ------------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------------
	wire [31:0] ctl_word = {12'h000, microsecond_tick_count, 3'b000,
		drop_bad_timeout_beacons, 2'b00, auto_table_purge, enable};
	wire [7:0]  topo = (state == ST_IDLE) ? `RRN_TOPO_LINEAR : `RRN_TOPO_RING;
	wire [31:0] stat_word = {topo, 6'b000000, link_up, node_code(state),
		6'b000000, last_beacon_port};

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			case (reg_addr)
				`RRN_ADDR_CONTROL:     reg_rdata <= ctl_word;
				`RRN_ADDR_STATUS:      reg_rdata <= stat_word;
				`RRN_ADDR_FRAME_TYPE:  reg_rdata <= {16'h0000, ring_frame_ethertype};
				`RRN_ADDR_IRQ_MASK:    reg_rdata <= {{(32-`RRN_IRQ_BITS){1'b0}}, irq_mask};
				`RRN_ADDR_IRQ_STATUS:  reg_rdata <= {{(32-`RRN_IRQ_BITS){1'b0}}, irq_status};
				`RRN_ADDR_TIMEOUT_CAP: reg_rdata <= captured_beacon_timeout;
				`RRN_ADDR_STATS:       reg_rdata <= {ignored_beacon_count, ring_frame_count};
				default:               reg_rdata <= 32'h00000000;
			endcase
		end else
			reg_rdata <= 32'h00000000;
	end

endmodule

`default_nettype wire

// ---- rrn_lookup_model.sv ----
// Purpose: Lookup engine stand-in that answers purge requests.
// Assumes: A purge request is a level held until acknowledged.
// Notes:   DLY sets how many cycles the engine needs before it answers.
`timescale 1ns/1ps
`default_nettype none
module rrn_lookup_model #(
	parameter int DLY = 2
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic purge_req,
	output var  logic purge_ack,
	output var  int   cmds
);
	int n;
	// The acknowledge is one cycle long so that a held request is never counted twice.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			n <= 0;
			purge_ack <= 1'b0;
			cmds <= 0;
		end else begin
			purge_ack <= 1'b0;
			if (purge_req && !purge_ack) begin
				n <= n + 1;
				if (n == DLY) begin
					n <= 0;
					purge_ack <= 1'b1;
					cmds <= cmds + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- rrn_ctrl_sva.sv ----
// Purpose: Port-level assertions for the ring node control.
// Assumes: Control register writes are seen at the register port.
// Notes:   Enable and auto purge are shadowed from control writes.
`include "rrn_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module rrn_ctrl_sva (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        rx_valid,
	input wire logic [47:0] rx_src_addr,
	input wire logic [47:0] local_addr,
	input wire logic [1:0]  link_up,
	input wire logic        rx_done,
	input wire logic        rx_drop,
	input wire logic        rx_ring_frame,
	input wire logic        purge_req,
	input wire logic [7:0]  purge_port_mask,
	input wire logic        purge_ack
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic en;
	logic ap;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en <= 1'b0;
			ap <= 1'b0;
		end else if (reg_wr && reg_addr == `RRN_ADDR_CONTROL) begin
			en <= reg_wdata[0];
			ap <= reg_wdata[1];
		end
	end
	sequence s_st;
		reg_rd && reg_addr == `RRN_ADDR_STATUS;
	endsequence
	a_done_after_valid: assert property (rx_valid |=> rx_done)
		else $error("done missing");
	a_off_no_ring: assert property (rx_valid && !en |=> !rx_ring_frame && !rx_drop)
		else $error("frame handled while off");
	a_loop_drop: assert property (rx_valid && en && rx_src_addr == local_addr |=> rx_drop)
		else $error("own frame kept");
	a_drop_own_only: assert property (rx_valid && rx_src_addr != local_addr |=> !rx_drop)
		else $error("foreign frame dropped");
	a_link_mirror: assert property (s_st |=> reg_rdata[17:16] == $past(link_up))
		else $error("link flags wrong");
	a_topo_state: assert property (s_st |=> reg_rdata[31:24] == {7'h00, reg_rdata[15:8] != 8'h00})
		else $error("topology wrong");
	a_state_code: assert property (s_st |=> reg_rdata[15:8] <= 8'h02)
		else $error("node code unused");
	a_purge_mask: assert property (purge_req |-> purge_port_mask == `RRN_PURGE_MASK)
		else $error("purge mask wrong");
	a_purge_auto: assert property ($rose(purge_req) |-> $past(ap))
		else $error("purge without auto");
	a_purge_hold: assert property (purge_req && !purge_ack |=> purge_req)
		else $error("purge dropped early");
endmodule
bind rrn_ctrl rrn_ctrl_sva u_sva (.*);
`default_nettype wire

// ---- rrn_ctrl_tb.sv ----
// Purpose: Self-checking bench for the ring node control.
// Assumes: Frames are beacons, from the supervisor except the last two; tick count 3.
// Notes:   A small reference model predicts frame verdicts, status and statistics.
`include "rrn_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module rrn_ctrl_tb;
	logic        clk, resetn, reg_wr, reg_rd, rx_valid, rx_port, rx_beacon, rx_from_sup;
	logic        rx_ring_fault, rx_done, rx_drop, rx_ring_frame, purge_req, purge_ack, irq;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, rx_timeout;
	logic [15:0] rx_ethertype;
	logic [47:0] rx_src_addr, local_addr;
	logic [1:0]  link_up;
	logic [7:0]  purge_port_mask;
	int          cmds, fails, total_checks, node, last, ring_cnt, ign_cnt;
	int          tmo[3] = '{199, 500001, 500000};
	bit   [31:0] seed = 32'h50;
	bit   [15:0] etype;
	bit          en, screen;
	rrn_ctrl u_dut (.*);
	rrn_lookup_model #(.DLY(2)) u_lookup (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Model and bus tasks
	// ------------------------------------------------------------
	function automatic bit [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic bit [31:0] st_exp();
		return {7'h00, node != 0, 6'h00, link_up, node[7:0], 6'h00, last[1:0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic fr(input bit p, input bit [15:0] t, input bit [47:0] sa, input bit f,
		input int tm);
		bit ring;
		ring = en && t == etype;
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_port <= p;
		rx_ethertype <= t;
		rx_src_addr <= sa;
		rx_ring_fault <= f;
		rx_timeout <= tm;
		@(posedge clk);
		rx_valid <= 1'b0;
		#1 chk({rx_done, rx_ring_frame, rx_drop}, {1'b1, ring, en && sa == local_addr});
		if (ring) begin
			ring_cnt++;
			if (screen && (tm < 200 || tm > 500000)) ign_cnt++;
			else if (rx_from_sup) begin
				node = f ? 2 : 1;
				last |= 1 << p;
			end
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		finish_test();
	end
	initial begin
		{reg_wr, reg_rd, rx_valid, rx_port, rx_ring_fault, resetn} = '0;
		{reg_addr, reg_wdata, rx_timeout, rx_ethertype, rx_src_addr} = '0;
		{rx_beacon, rx_from_sup} = 2'b11;
		local_addr = 48'h02000000A001;
		link_up = 2'(xs());
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd(`RRN_ADDR_CONTROL, 32'h00006400);
		rd(`RRN_ADDR_STATUS, st_exp());
		rd(32'h44053C1C, 32'h00000000);
		etype = 16'(xs());
		wr(`RRN_ADDR_FRAME_TYPE, {16'h0000, etype});
		rd(`RRN_ADDR_FRAME_TYPE, {16'h0000, etype});
		fr(0, etype, 48'h000000000001, 0, 1000);
		wr(`RRN_ADDR_CONTROL, 32'h00000303);
		en = 1;
		fr(0, etype ^ 16'h0001, 48'h000000000001, 0, 1000);
		fr(0, etype, 48'h000000000001, 0, 200);
		chk({purge_req, purge_port_mask}, 32'h00000103);
		rd(`RRN_ADDR_STATUS, st_exp());
		repeat (540) @(posedge clk);
		rd(`RRN_ADDR_STATUS, st_exp());
		repeat (80) @(posedge clk);
		node = 0;
		last = 0;
		rd(`RRN_ADDR_STATUS, st_exp());
		chk(cmds, 1);
		wr(`RRN_ADDR_CONTROL, 32'h00000313);
		screen = 1;
		foreach (tmo[i]) begin
			fr(1, etype, 48'h000000000001, 1, tmo[i]);
			rd(`RRN_ADDR_TIMEOUT_CAP, tmo[i]);
			rd(`RRN_ADDR_STATUS, st_exp());
		end
		// A beacon from another supervisor must leave node state and port flags alone.
		@(posedge clk) rx_from_sup <= 1'b0;
		fr(0, etype, 48'h000000000001, 0, 1000);
		rd(`RRN_ADDR_STATUS, st_exp());
		fr(0, etype ^ 16'h0002, local_addr, 0, 0);
		chk(irq, 0);
		wr(`RRN_ADDR_IRQ_MASK, 32'h00000008);
		#1 chk(irq, 1);
		wr(`RRN_ADDR_IRQ_STATUS, 32'h00000008);
		#1 chk(irq, 0);
		wr(`RRN_ADDR_IRQ_MASK, 32'h00000002);
		#1 chk(irq, 1);
		wr(`RRN_ADDR_IRQ_STATUS, 32'h00000002);
		#1 chk(irq, 0);
		chk(cmds, 2);
		rd(`RRN_ADDR_STATS, {ign_cnt[15:0], ring_cnt[15:0]});
		wr(`RRN_ADDR_CONTROL, 32'h00000000);
		en = 0;
		node = 0;
		last = 0;
		rd(`RRN_ADDR_STATS, 32'h00000000);
		rd(`RRN_ADDR_STATUS, st_exp());
		finish_test();
	end
endmodule
`default_nettype wire
